// File: bench/edp_counter_assertions.sv
// port-level checker for the counter channel
`timescale 1ns/1ns
module edp_counter_assertions
    import edp_pkg::*;
#(
    parameter int WIDTH = EDP_WIDTH
) (
    // clock, reset and controls
    input wire logic mclk,
    input wire logic srst,
    input wire edp_mode_t mode,
    input wire logic runEnable,
    input wire logic flopInitBit,
    input wire logic flopInitWrite,
    input wire logic [WIDTH-1:0] periodWriteData,
    input wire logic periodWrite,
    // outputs
    input wire logic dividerOutputPin,
    input wire logic modulatedOutputPin,
    input wire logic matchInterrupt,
    input wire logic [WIDTH-1:0] counterValue,
    input wire logic [WIDTH-1:0] periodCompare,
    input wire logic outputFlop
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (srst);
    a_pins_inverse: assert property (dividerOutputPin == !outputFlop && modulatedOutputPin == !outputFlop)
        else $error("pin not inverse of flop");
    a_reset_clear: assert property (disable iff (1'b0) srst |=> !outputFlop && !matchInterrupt)
        else $error("reset left flop or interrupt set");
    a_stop_hold: assert property (!runEnable && !flopInitWrite |=> $stable(outputFlop) && $stable(counterValue))
        else $error("stopped counter moved");
    a_flop_load: assert property (!runEnable && flopInitWrite |=> outputFlop == $past(flopInitBit))
        else $error("flop not loaded");
    a_pwm_wrap: assert property (mode == EDP_MODE_PWM && !$past(srst) && $past(counterValue) == 8'hff
        && counterValue == 8'h00 |-> matchInterrupt && outputFlop != $past(outputFlop))
        else $error("wrap without toggle and interrupt");
    a_div_match: assert property (mode == EDP_MODE_DIVIDER && !$past(srst) && $past(runEnable)
        && $changed(outputFlop) |-> matchInterrupt && counterValue == 8'h00)
        else $error("divider toggle without match");
    a_event_clear: assert property (mode == EDP_MODE_EVENT && matchInterrupt |-> counterValue == 8'h00)
        else $error("event match without clear");
    a_period_now: assert property (periodWrite |=> periodCompare == $past(periodWriteData))
        else $error("period write late");
endmodule
bind edp_counter edp_counter_assertions #(.WIDTH(WIDTH)) u_chk (.mclk, .srst, .mode, .runEnable, .flopInitBit,
    .flopInitWrite, .periodWriteData, .periodWrite, .dividerOutputPin, .modulatedOutputPin, .matchInterrupt,
    .counterValue, .periodCompare, .outputFlop);

// File: bench/edp_pulse_src.sv
// partner model: external pulse source on the count input
`timescale 1ns/1ns
module edp_pulse_src (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // one-cycle request for one low pulse
    input wire logic go,
    // count input, idles high
    output logic pin
);
    logic [1:0] lowLeft;
    // low lasts three cycles, callers space requests so high lasts longer still
    always_ff @(posedge mclk) begin
        if (srst) lowLeft <= 2'h0;
        else if (go) lowLeft <= 2'h3;
        else if (lowLeft != 2'h0) lowLeft <= lowLeft - 2'h1;
    end
    assign pin = (lowLeft == 2'h0);
endmodule

// File: bench/tb.sv
// self-checking bench for the counter channel
`timescale 1ns/1ns
module tb;
    import edp_pkg::*;
    typedef struct packed {edp_mode_t m; edp_src_t s; logic t; logic [7:0] p; logic [7:0] n;
        logic [11:0] e;} edp_row_t;
    // event rows: edges and end count; others: cycles between interrupts
    // compare values stay inside their legal ranges
    localparam edp_row_t ROWS [10] = '{
        '{EDP_MODE_EVENT, EDP_SRC_MAIN, 1'b0, 8'h05, 8'h07, 12'h002},
        '{EDP_MODE_EVENT, EDP_SRC_MAIN, 1'b0, 8'h01, 8'h02, 12'h000},
        '{EDP_MODE_DIVIDER, EDP_SRC_DIV1, 1'b0, 8'h03, 8'h00, 12'h006},
        '{EDP_MODE_DIVIDER, EDP_SRC_DIV3, 1'b0, 8'h03, 8'h00, 12'h018},
        '{EDP_MODE_DIVIDER, EDP_SRC_DIV5, 1'b0, 8'h03, 8'h00, 12'h060},
        '{EDP_MODE_DIVIDER, EDP_SRC_DIV7, 1'b0, 8'h02, 8'h00, 12'h100},
        // sub ticks come every fourth cycle
        '{EDP_MODE_DIVIDER, EDP_SRC_SUB, 1'b0, 8'h03, 8'h00, 12'h00c},
        '{EDP_MODE_DIVIDER, EDP_SRC_SLOWEST, 1'b1, 8'h02, 8'h00, 12'h040},
        '{EDP_MODE_DIVIDER, EDP_SRC_SLOWEST, 1'b0, 8'h01, 8'h00, 12'h800},
        '{EDP_MODE_PWM, EDP_SRC_MAIN, 1'b0, 8'h20, 8'h00, 12'h100}};
    logic mclk, srst, runEnable, flopInitBit, flopInitWrite, wr, go, pin, divPin, modPin, irq, flop, tap;
    edp_mode_t mode;
    edp_src_t srcSelect;
    logic [7:0] wd, counterValue, dutyReadback, per;
    logic [1:0] subPh = 2'h0;
    int mismatches, testsRun, irqs, base, g, h;
    edp_pulse_src src (.mclk, .srst, .go, .pin);
    edp_counter uut (.mclk, .srst, .mainTick(1'b1), .subTick(subPh == 2'h3), .mode, .srcSelect, .tapSelect(tap),
        .runEnable, .flopInitBit, .flopInitWrite, .periodWriteData(wd), .periodWrite(wr), .dutyWriteData(wd),
        .dutyWrite(wr), .countInputPin(pin), .dividerOutputPin(divPin), .modulatedOutputPin(modPin),
        .matchInterrupt(irq), .counterValue, .periodCompare(per), .dutyReadback, .outputFlop(flop));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(negedge mclk) if (irq === 1'b1) irqs++;
    always @(posedge mclk) subPh <= subPh + 2'h1;
    initial begin
        #160000;
        mismatches++;
        wrap_up();
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // g counts cycles to the next interrupt, h those with the flop as it was
    task automatic wait_irq();
        logic f;
        f = flop;
        g = 0;
        h = 0;
        do begin
            @(negedge mclk);
            g++;
            if (flop === f) h++;
        end while (irq !== 1'b1 && g < 2200);
    endtask
    task automatic wrap_up();
        $display("tb: %0d checks, %0d mismatches", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        mode = EDP_MODE_OFF;
        srcSelect = EDP_SRC_MAIN;
        tap = 1'b0;
        {runEnable, flopInitBit, flopInitWrite, wr, go} = 5'h00;
        wd = 8'h00;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk) check("reset", 16'({dutyReadback, divPin, modPin, flop, irq}), 16'h0ffc);
        $display("reset done");
        foreach (ROWS[i]) begin
            @(posedge mclk) srst <= 1'b1;
            mode <= ROWS[i].m;
            srcSelect <= ROWS[i].s;
            tap <= ROWS[i].t;
            runEnable <= 1'b0;
            wd <= ROWS[i].p;
            wr <= 1'b1;
            @(posedge mclk) srst <= 1'b0;
            @(posedge mclk) wr <= 1'b0;
            runEnable <= 1'b1;
            base = irqs;
            @(negedge mclk) check("period", 16'(per), 16'(ROWS[i].p));
            if (ROWS[i].m == EDP_MODE_EVENT) begin
                repeat (ROWS[i].n) begin
                    @(posedge mclk) go <= 1'b1;
                    @(posedge mclk) go <= 1'b0;
                    repeat (6) @(posedge mclk);
                end
                repeat (6) @(negedge mclk);
                check("count", 16'(counterValue), 16'(ROWS[i].e));
                check("matches", 16'(irqs - base), 16'(ROWS[i].n / ROWS[i].p));
            end else begin
                wait_irq();
                wait_irq();
                check("gap", 16'(g), 16'(ROWS[i].e));
            end
            $display("row %0d done", i);
        end
        check("width", 16'(h), 16'h0020);
        // new duty lands just after a wrap, well before the next one
        @(posedge mclk) wd <= 8'h40;
        wr <= 1'b1;
        @(posedge mclk) wr <= 1'b0;
        @(negedge mclk) check("old duty", 16'(dutyReadback), 16'h0020);
        wait_irq();
        check("new duty", 16'(dutyReadback), 16'h0040);
        wait_irq();
        check("new width", 16'(h), 16'h0040);
        $display("duty buffer done");
        @(posedge mclk) runEnable <= 1'b0;
        for (int b = 1; b >= 0; b--) begin
            @(posedge mclk) flopInitBit <= b[0];
            flopInitWrite <= 1'b1;
            @(posedge mclk) flopInitWrite <= 1'b0;
            @(negedge mclk) check("load", 16'({divPin, modPin}), 16'({~b[0], ~b[0]}));
        end
        $display("stop and load done");
        wrap_up();
    end
endmodule

// File: verilog/edp_counter.sv
// 8-bit counter channel: event counting, divider output and pulse-width modulation
`timescale 1ns/1ns
module edp_counter
    import edp_pkg::*;
#(
    parameter int WIDTH = EDP_WIDTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // oscillator tick enables, one cycle each
    input wire logic mainTick,
    input wire logic subTick,
    // control bits
    input wire edp_mode_t mode,
    input wire edp_src_t srcSelect,
    input wire logic tapSelect,
    input wire logic runEnable,
    input wire logic flopInitBit,
    input wire logic flopInitWrite,
    // compare register writes
    input wire logic [WIDTH-1:0] periodWriteData,
    input wire logic periodWrite,
    input wire logic [WIDTH-1:0] dutyWriteData,
    input wire logic dutyWrite,
    // external count input
    input wire logic countInputPin,
    // outputs
    output logic dividerOutputPin,
    output logic modulatedOutputPin,
    output logic matchInterrupt,
    output logic [WIDTH-1:0] counterValue,
    output logic [WIDTH-1:0] periodCompare,
    output logic [WIDTH-1:0] dutyReadback,
    output logic outputFlop
);
    logic [WIDTH-1:0] count_reg, count_next;
    logic [WIDTH-1:0] period_reg, period_next;
    logic [WIDTH-1:0] dutyBuf_reg, dutyBuf_next;
    logic [WIDTH-1:0] dutyActive_reg, dutyActive_next;
    logic flop_reg, flop_next;
    logic irq_reg, irq_next;
    logic syncA_reg, syncB_reg, syncC_reg;
    logic srcTick;
    logic fallEdge;
    logic step;

    edp_prescaler #(
        .DIV_WIDTH(EDP_DIV_WIDTH)
    ) uPrescaler (
        .mclk(mclk),
        .srst(srst),
        .mainTick(mainTick),
        .subTick(subTick),
        .tapSelect(tapSelect),
        .srcSelect(srcSelect),
        .srcTick(srcTick)
    );

    // two-flop synchroniser then one more stage for the edge compare
    always_ff @(posedge mclk) begin
        if (srst) begin
            syncA_reg <= 1'b1;
            syncB_reg <= 1'b1;
            syncC_reg <= 1'b1;
        end else begin
            syncA_reg <= countInputPin;
            syncB_reg <= syncA_reg;
            syncC_reg <= syncB_reg;
        end
    end
    assign fallEdge = syncC_reg && !syncB_reg;

    // counting step: input edges in event mode, prescaled clock in divider and PWM modes, none when off
    always_comb begin
        case (mode)
            EDP_MODE_EVENT: step = runEnable && fallEdge;
            EDP_MODE_DIVIDER,
            EDP_MODE_PWM: step = runEnable && srcTick;
            default: step = 1'b0;
        endcase
    end

    always_comb begin
        count_next = count_reg;
        period_next = period_reg;
        dutyBuf_next = dutyBuf_reg;
        dutyActive_next = dutyActive_reg;
        flop_next = flop_reg;
        irq_next = 1'b0;
        // unbuffered: a write is compared at once
        if (periodWrite) begin
            period_next = periodWriteData;
        end
        if (dutyWrite) begin
            dutyBuf_next = dutyWriteData;
        end
        // flop load only takes while stopped, so a stop holds the pin
        if (flopInitWrite && !runEnable) begin
            flop_next = flopInitBit;
        end
        if (!runEnable) begin
            dutyActive_next = dutyWrite ? dutyWriteData : dutyBuf_reg;
        end else if (step) begin
            case (mode)
                EDP_MODE_EVENT: begin
                    if (count_reg + 1'b1 == period_reg) begin
                        count_next = EDP_COUNT_RESET;
                        irq_next = 1'b1;
                    end else begin
                        count_next = count_reg + 1'b1;
                    end
                end
                EDP_MODE_DIVIDER: begin
                    if (count_reg + 1'b1 == period_reg) begin
                        count_next = EDP_COUNT_RESET;
                        flop_next = !flop_reg;
                        irq_next = 1'b1;
                    end else begin
                        count_next = count_reg + 1'b1;
                    end
                end
                EDP_MODE_PWM: begin
                    count_next = count_reg + 1'b1;
                    if (&count_reg) begin
                        // overflow: toggle back, clear, interrupt, take new duty
                        flop_next = !flop_reg;
                        irq_next = 1'b1;
                        dutyActive_next = dutyBuf_reg;
                    end else if (count_reg + 1'b1 == dutyActive_reg) begin
                        flop_next = !flop_reg;
                    end
                end
                default: begin
                    count_next = count_reg;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            count_reg <= EDP_COUNT_RESET;
            period_reg <= EDP_PERIOD_RESET;
            dutyBuf_reg <= EDP_DUTY_RESET;
            dutyActive_reg <= EDP_DUTY_RESET;
            flop_reg <= EDP_FLOP_RESET;
            irq_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            period_reg <= period_next;
            dutyBuf_reg <= dutyBuf_next;
            dutyActive_reg <= dutyActive_next;
            flop_reg <= flop_next;
            irq_reg <= irq_next;
        end
    end

    // pins drive the inverse of the flop
    assign dividerOutputPin = !flop_reg;
    assign modulatedOutputPin = !flop_reg;
    assign matchInterrupt = irq_reg;
    assign counterValue = count_reg;
    assign periodCompare = period_reg;
    // while modulating, reads show the active value until transfer
    assign dutyReadback = (mode == EDP_MODE_PWM && runEnable) ? dutyActive_reg : dutyBuf_reg;
    assign outputFlop = flop_reg;
endmodule

// File: verilog/edp_pkg.sv
// constants and types for the 8-bit event/divider/modulation counter channel
package edp_pkg;
    localparam int EDP_WIDTH = 8;
    localparam logic [7:0] EDP_COUNT_RESET = 8'h00;
    localparam logic [7:0] EDP_PERIOD_RESET = 8'hff;
    localparam logic [7:0] EDP_DUTY_RESET = 8'hff;
    localparam logic EDP_FLOP_RESET = 1'b0;
    localparam int EDP_DIV_WIDTH = 11;
    // control register bit positions
    localparam int EDP_BIT_RUN = 3;
    localparam int EDP_BIT_FLOP = 7;

    typedef enum logic [1:0] {
        EDP_MODE_EVENT,
        EDP_MODE_DIVIDER,
        EDP_MODE_PWM,
        EDP_MODE_OFF
    } edp_mode_t;

    // source clock selection
    typedef enum logic [2:0] {
        EDP_SRC_SLOWEST,
        EDP_SRC_DIV7,
        EDP_SRC_DIV5,
        EDP_SRC_DIV3,
        EDP_SRC_SUB,
        EDP_SRC_DIV1,
        EDP_SRC_MAIN,
        EDP_SRC_NONE
    } edp_src_t;
endpackage

// File: verilog/edp_prescaler.sv
// prescaler making one-cycle tick enables from main and sub oscillator ticks
`timescale 1ns/1ns
module edp_prescaler
    import edp_pkg::*;
#(
    parameter int DIV_WIDTH = EDP_DIV_WIDTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // oscillator tick enables and source selects
    input wire logic mainTick,
    input wire logic subTick,
    input wire logic tapSelect,
    input wire edp_src_t srcSelect,
    // selected source tick
    output logic srcTick
);
    logic [DIV_WIDTH-1:0] mainDiv_reg, mainDiv_next;
    logic [2:0] subDiv_reg, subDiv_next;
    logic [DIV_WIDTH-1:0] mainCarry;
    logic subCarry;

    // a stage ticks when all lower bits roll over
    genvar g;
    generate
        for (g = 0; g < DIV_WIDTH; g++) begin : gCarry
            assign mainCarry[g] = mainTick && (&mainDiv_reg[g:0]);
        end
    endgenerate
    assign subCarry = subTick && (&subDiv_reg);

    always_comb begin
        mainDiv_next = mainDiv_reg;
        subDiv_next = subDiv_reg;
        if (mainTick) begin
            mainDiv_next = mainDiv_reg + 1'b1;
        end
        if (subTick) begin
            subDiv_next = subDiv_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mainDiv_reg <= '0;
            subDiv_reg <= '0;
        end else begin
            mainDiv_reg <= mainDiv_next;
            subDiv_reg <= subDiv_next;
        end
    end

    always_comb begin
        case (srcSelect)
            EDP_SRC_SLOWEST: srcTick = tapSelect ? subCarry : mainCarry[10];
            EDP_SRC_DIV7: srcTick = mainCarry[6];
            EDP_SRC_DIV5: srcTick = mainCarry[4];
            EDP_SRC_DIV3: srcTick = mainCarry[2];
            EDP_SRC_SUB: srcTick = subTick;
            EDP_SRC_DIV1: srcTick = mainCarry[0];
            EDP_SRC_MAIN: srcTick = mainTick;
            default: srcTick = 1'b0;
        endcase
    end
endmodule
